// ### src/cpr_reconfig_top.v
// Channel and multiplier PLL reconfiguration with core clock selection.
// Assumes a plain register port and one 100 MHz clock.
`timescale 1ns/1ps
`include "cpr_consts.vh"
module cpr_reconfig_top (
  input wire mclk_in,
  input wire rst_in,
  input wire [3:0] addr_in,
  input wire [15:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  output reg [15:0] rd_data_out,
  output reg busy_out,
  output reg [`CPR_NUM_CH-1:0] ch_tx_pll_sel_out,
  output reg [`CPR_NUM_CH*2-1:0] tx_fifo_wclk_sel_out,
  output reg [`CPR_NUM_CH-1:0] rx_fifo_rclk_fab_out,
  output reg [`CPR_REFCLK_W-1:0] first_multiplier_pll_ref_out,
  output reg [`CPR_REFCLK_W-1:0] second_multiplier_pll_ref_out
);
  // FIFO write clock select codes
  localparam [1:0] WCLK_OWN = 2'h0;
  localparam [1:0] WCLK_CH0 = 2'h1;
  localparam [1:0] WCLK_FAB = 2'h2;
  localparam [1:0] WCLK_NONE = 2'h3;

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_READ = 2'h1;
  localparam [1:0] ST_APPLY = 2'h2;

  reg [1:0] state_reg;
  reg [`CPR_IMG_AW-1:0] ptr_reg;
  reg [`CPR_CH_W-1:0] tgt_reg;
  reg [`CPR_IMG_AW-1:0] img_addr_reg;
  reg first_cycle_reg;
  reg err_dir_reg;
  reg err_ref_reg;
  reg done_reg;
  reg [2:0] clksel_reg;
  reg alt_idx_reg;
  // Per-channel shadow of the applied settings
  reg [`CPR_NUM_CH*2-1:0] kind_reg;
  reg [`CPR_NUM_CH-1:0] pmaonly_reg;
  reg [`CPR_NUM_CH*16-1:0] csl_reg;
  reg [`CPR_NUM_CH*16-1:0] pma_reg;
  reg [`CPR_NUM_CH*16-1:0] div_reg;
  reg [15:0] pll_cfg_reg [0:1];
  reg [15:0] chan_word_reg;
  reg [15:0] pll_word_reg;
  // Staged channel words; nothing lands until the image is judged legal
  reg [15:0] csl_word_reg;
  reg [15:0] pma_word_reg;
  reg [15:0] div_word_reg;
  reg [`CPR_NUM_CH-1:0] lpll_reg;

  wire [15:0] img_q;
  wire img_we;
  wire [`CPR_IMG_AW-1:0] mem_addr;

  assign img_we = wr_in && addr_in == `CPR_A_IMGDATA && state_reg == ST_IDLE;
  assign mem_addr = (state_reg == ST_IDLE) ? img_addr_reg : ptr_reg;

  cpr_image_mem u_mem (
    .mclk_in(mclk_in),
    .wr_en_in(img_we),
    .addr_in(mem_addr),
    .wr_data_in(wr_data_in),
    .rd_data_out(img_q)
  );

  // Direction change check: transmit-only and receive-only never swap
  function dir_illegal;
    input [1:0] old_kind;
    input [1:0] new_kind;
    begin
      dir_illegal = (old_kind == `CPR_KIND_TXONLY && new_kind == `CPR_KIND_RXONLY) ||
        (old_kind == `CPR_KIND_RXONLY && new_kind == `CPR_KIND_TXONLY);
    end
  endfunction

  // Reference clock index field of the channel word
  function [`CPR_REFCLK_W-1:0] ref_of;
    input [15:0] w;
    begin
      ref_of = w[`CPR_F_REF_LO+3:`CPR_F_REF_LO];
    end
  endfunction

  // Channel kind field of the channel word
  function [1:0] kind_of;
    input [15:0] w;
    begin
      kind_of = w[`CPR_F_KIND_LO+1:`CPR_F_KIND_LO];
    end
  endfunction

  // Physical PLL for a logical index; alternate PLL sits at the second slot only while alt is 0, else the slots swap
  function phys_pll;
    input lidx;
    input alt;
    begin
      phys_pll = lidx ^ alt;
    end
  endfunction

  integer i;
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      ptr_reg <= 6'h00;
      tgt_reg <= 2'h0;
      img_addr_reg <= 6'h00;
      first_cycle_reg <= 1'b1;
      err_dir_reg <= 1'b0;
      err_ref_reg <= 1'b0;
      done_reg <= 1'b0;
      clksel_reg <= 3'h0;
      alt_idx_reg <= 1'b0;
      kind_reg <= {`CPR_NUM_CH*2{1'b0}};
      pmaonly_reg <= {`CPR_NUM_CH{1'b0}};
      csl_reg <= {`CPR_NUM_CH*16{1'b0}};
      pma_reg <= {`CPR_NUM_CH*16{1'b0}};
      div_reg <= {`CPR_NUM_CH*16{1'b0}};
      pll_cfg_reg[0] <= 16'h0000;
      pll_cfg_reg[1] <= 16'h0000;
      chan_word_reg <= 16'h0000;
      pll_word_reg <= 16'h0000;
      csl_word_reg <= 16'h0000;
      pma_word_reg <= 16'h0000;
      div_word_reg <= 16'h0000;
      lpll_reg <= {`CPR_NUM_CH{1'b0}};
      busy_out <= 1'b0;
      first_multiplier_pll_ref_out <= 4'h0;
      second_multiplier_pll_ref_out <= 4'h0;
    end else begin
      first_cycle_reg <= 1'b0;
      if (wr_in && addr_in == `CPR_A_CLKSEL) begin
        clksel_reg <= wr_data_in[2:0];
      end
      if (wr_in && addr_in == `CPR_A_ALTIDX) begin
        alt_idx_reg <= wr_data_in[0];
      end
      if (wr_in && addr_in == `CPR_A_IMGADDR) begin
        img_addr_reg <= wr_data_in[5:0];
      end else if (img_we || (rd_in && addr_in == `CPR_A_IMGDATA)) begin
        img_addr_reg <= img_addr_reg + 6'h01;
      end
      case (state_reg)
        ST_IDLE: begin
          // Busy held low in the first cycle after reset
          if (!first_cycle_reg && wr_in && addr_in == `CPR_A_CTRL &&
              wr_data_in[`CPR_C_START]) begin
            tgt_reg <= wr_data_in[`CPR_C_CH_LO+1:`CPR_C_CH_LO];
            ptr_reg <= 6'h00;
            err_dir_reg <= 1'b0;
            err_ref_reg <= 1'b0;
            done_reg <= 1'b0;
            busy_out <= 1'b1;
            state_reg <= ST_READ;
          end
        end
        ST_READ: begin
          // Memory answers one cycle after ptr; capture words in flight
          if (ptr_reg != 6'h00) begin
            case (ptr_reg - 6'h01)
              `CPR_W_CHAN: chan_word_reg <= img_q;
              `CPR_W_CSL: csl_word_reg <= img_q;
              `CPR_W_PMA: pma_word_reg <= img_q;
              `CPR_W_TXDIV: div_word_reg[7:0] <= img_q[7:0];
              `CPR_W_RXDIV: div_word_reg[15:8] <= img_q[7:0];
              `CPR_W_PLL: pll_word_reg <= img_q;
              default: ;
            endcase
          end
          if (ptr_reg == `CPR_W_PLL + 6'h01) begin
            state_reg <= ST_APPLY;
          end else begin
            ptr_reg <= ptr_reg + 6'h01;
          end
        end
        ST_APPLY: begin
          if (dir_illegal(kind_reg[tgt_reg*2 +: 2], kind_of(chan_word_reg))) begin
            err_dir_reg <= 1'b1;
          end else if (ref_of(chan_word_reg) >= `CPR_MAX_REFCLK) begin
            err_ref_reg <= 1'b1;
          end else begin
            kind_reg[tgt_reg*2 +: 2] <= kind_of(chan_word_reg);
            csl_reg[tgt_reg*16 +: 16] <= csl_word_reg;
            pma_reg[tgt_reg*16 +: 16] <= pma_word_reg;
            div_reg[tgt_reg*16 +: 16] <= div_word_reg;
            pmaonly_reg[tgt_reg] <= chan_word_reg[`CPR_F_PMAONLY];
            lpll_reg[tgt_reg] <= chan_word_reg[`CPR_F_LPLL];
            // Only the physical PLL that the image's logical index maps to under alt_idx_reg is rewritten
            if (phys_pll(chan_word_reg[`CPR_F_LPLL], alt_idx_reg)) begin
              pll_cfg_reg[1] <= pll_word_reg;
              second_multiplier_pll_ref_out <= ref_of(chan_word_reg);
            end else begin
              pll_cfg_reg[0] <= pll_word_reg;
              first_multiplier_pll_ref_out <= ref_of(chan_word_reg);
            end
            done_reg <= 1'b1;
          end
          busy_out <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          busy_out <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Clock routing, recomputed every cycle from settings
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ch_tx_pll_sel_out <= {`CPR_NUM_CH{1'b0}};
      tx_fifo_wclk_sel_out <= {`CPR_NUM_CH*2{1'b0}};
      rx_fifo_rclk_fab_out <= {`CPR_NUM_CH{1'b0}};
    end else begin
      for (i = 0; i < `CPR_NUM_CH; i = i + 1) begin
        ch_tx_pll_sel_out[i] <= phys_pll(lpll_reg[i], alt_idx_reg);
        if (pmaonly_reg[i]) begin
          tx_fifo_wclk_sel_out[i*2 +: 2] <= WCLK_NONE;
          rx_fifo_rclk_fab_out[i] <= 1'b0;
        end else begin
          if (clksel_reg[`CPR_K_TXFAB]) begin
            tx_fifo_wclk_sel_out[i*2 +: 2] <= WCLK_FAB;
          end else if (clksel_reg[`CPR_K_SHARED] && i != 0) begin
            tx_fifo_wclk_sel_out[i*2 +: 2] <= WCLK_CH0;
          end else begin
            tx_fifo_wclk_sel_out[i*2 +: 2] <= WCLK_OWN;
          end
          rx_fifo_rclk_fab_out[i] <= clksel_reg[`CPR_K_RXFAB];
        end
      end
    end
  end

  // Register read port, data one cycle after strobe
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 16'h0000;
    end else if (rd_in) begin
      case (addr_in)
        `CPR_A_CTRL: rd_data_out <= {10'h000, tgt_reg, 4'h0};
        `CPR_A_STATUS: rd_data_out <= {12'h000, done_reg, err_ref_reg, err_dir_reg, busy_out};
        `CPR_A_CLKSEL: rd_data_out <= {13'h0000, clksel_reg};
        `CPR_A_ALTIDX: rd_data_out <= {15'h0000, alt_idx_reg};
        `CPR_A_IMGADDR: rd_data_out <= {10'h000, img_addr_reg};
        `CPR_A_IMGDATA: rd_data_out <= img_q;
        `CPR_A_CHCFG: rd_data_out <= {7'h00, pmaonly_reg[tgt_reg], 1'b0,
          lpll_reg[tgt_reg], 4'h0, kind_reg[tgt_reg*2 +: 2]};
        `CPR_A_PLLCFG: rd_data_out <= pll_cfg_reg[ch_tx_pll_sel_out[tgt_reg]];
        `CPR_A_CSL: rd_data_out <= csl_reg[tgt_reg*16 +: 16];
        `CPR_A_PMA: rd_data_out <= pma_reg[tgt_reg*16 +: 16];
        `CPR_A_DIV: rd_data_out <= div_reg[tgt_reg*16 +: 16];
        default: rd_data_out <= 16'h0000;
      endcase
    end
  end
endmodule

// ### src/cpr_consts.vh
// Constants for the channel and PLL reconfiguration clock-select block.
// Assumes inclusion by bare name from the design files.
`ifndef CPR_CONSTS_VH
`define CPR_CONSTS_VH
`define CPR_IMG_WORDS 59
`define CPR_IMG_AW 6
`define CPR_IMG_DW 16
`define CPR_NUM_CH 4
`define CPR_CH_W 2
`define CPR_MAX_REFCLK 10
`define CPR_REFCLK_W 4
// Image word layout: word 0 holds channel kind, pll index, refclk index
`define CPR_W_CHAN 6'h00
`define CPR_W_CSL 6'h01
`define CPR_W_PMA 6'h02
`define CPR_W_TXDIV 6'h03
`define CPR_W_RXDIV 6'h04
`define CPR_W_PLL 6'h05
`define CPR_F_KIND_LO 0
`define CPR_F_LPLL 2
`define CPR_F_REF_LO 4
`define CPR_F_PMAONLY 8
// Channel kinds
`define CPR_KIND_DUPLEX 2'h0
`define CPR_KIND_TXONLY 2'h1
`define CPR_KIND_RXONLY 2'h2
// Register addresses on the plain port
`define CPR_A_CTRL 4'h0
`define CPR_A_STATUS 4'h1
`define CPR_A_CLKSEL 4'h2
`define CPR_A_ALTIDX 4'h3
`define CPR_A_IMGADDR 4'h4
`define CPR_A_IMGDATA 4'h5
`define CPR_A_CHCFG 4'h6
`define CPR_A_PLLCFG 4'h7
`define CPR_A_CSL 4'h8
`define CPR_A_PMA 4'h9
`define CPR_A_DIV 4'ha
// CTRL bits
`define CPR_C_START 0
`define CPR_C_CH_LO 4
// STATUS bits
`define CPR_S_BUSY 0
`define CPR_S_ERR_DIR 1
`define CPR_S_ERR_REF 2
`define CPR_S_DONE 3
// CLKSEL bits
`define CPR_K_TXFAB 0
`define CPR_K_RXFAB 1
`define CPR_K_SHARED 2
`endif

// ### src/cpr_image_mem.v
// Small single-port memory holding one reconfiguration image.
// Assumes one clock; read data registered one cycle after the address.
`timescale 1ns/1ps
`include "cpr_consts.vh"
module cpr_image_mem (
  input wire mclk_in,
  input wire wr_en_in,
  input wire [`CPR_IMG_AW-1:0] addr_in,
  input wire [`CPR_IMG_DW-1:0] wr_data_in,
  output reg [`CPR_IMG_DW-1:0] rd_data_out
);
  reg [`CPR_IMG_DW-1:0] mem [0:`CPR_IMG_WORDS-1];

  always @(posedge mclk_in) begin
    if (wr_en_in && addr_in < `CPR_IMG_WORDS) begin
      mem[addr_in] <= wr_data_in;
    end
    // Out-of-range words read as zero
    if (addr_in < `CPR_IMG_WORDS) begin
      rd_data_out <= mem[addr_in];
    end else begin
      rd_data_out <= {`CPR_IMG_DW{1'b0}};
    end
  end
endmodule

// ### test/cpr_reconfig_top_sva.sv
// Port assertions for the reconfiguration clock-select block.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module cpr_reconfig_sva (
  input wire mclk_in,
  input wire rst_in,
  input wire [3:0] addr_in,
  input wire [15:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  input wire [15:0] rd_data_out,
  input wire busy_out,
  input wire [3:0] ch_tx_pll_sel_out,
  input wire [7:0] tx_fifo_wclk_sel_out,
  input wire [3:0] rx_fifo_rclk_fab_out,
  input wire [3:0] first_multiplier_pll_ref_out,
  input wire [3:0] second_multiplier_pll_ref_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  wire start = wr_in && addr_in == 4'h0 && wr_data_in[0];
  wire clk_wr = wr_in && addr_in == 4'h2;
  wire [3:0] pma_ch;
  assign pma_ch = {&tx_fifo_wclk_sel_out[7:6], &tx_fifo_wclk_sel_out[5:4],
    &tx_fifo_wclk_sel_out[3:2], &tx_fifo_wclk_sel_out[1:0]};
  sequence apply_run;
    busy_out [*8] ##1 !busy_out;
  endsequence
  sequence quiet3;
    !$past(busy_out) && !$past(busy_out, 2) && !$past(busy_out, 3);
  endsequence
  busy_after_reset_a: assert property ($past(rst_in) |-> !busy_out ##1 !busy_out)
    else $error("busy high after reset");
  start_busy_a: assert property (start && !busy_out && !$past(rst_in) |=> apply_run)
    else $error("busy window wrong");
  busy_cause_a: assert property ($rose(busy_out) |-> $past(start))
    else $error("busy without start");
  ref_range_a: assert property (first_multiplier_pll_ref_out < 4'ha &&
    second_multiplier_pll_ref_out < 4'ha)
    else $error("refclk index out of range");
  ref_hold_a: assert property (quiet3 |-> $stable(first_multiplier_pll_ref_out) &&
    $stable(second_multiplier_pll_ref_out))
    else $error("pll ref changed while idle");
  pma_rx_a: assert property ((pma_ch & rx_fifo_rclk_fab_out) == 4'h0)
    else $error("pma-only channel with fabric clock");
  wsel_hold_a: assert property ($changed(tx_fifo_wclk_sel_out) |-> $past(clk_wr) ||
    $past(clk_wr, 2) || $past(busy_out) || $past(busy_out, 2) || $past(busy_out, 3))
    else $error("write clock select changed uncaused");
  rd_hold_a: assert property (!$past(rd_in) |-> $stable(rd_data_out))
    else $error("read data moved without read");
endmodule
bind cpr_reconfig_top cpr_reconfig_sva u_cpr_reconfig_sva (.mclk_in, .rst_in, .addr_in,
  .wr_data_in, .wr_in, .rd_in, .rd_data_out, .busy_out, .ch_tx_pll_sel_out,
  .tx_fifo_wclk_sel_out, .rx_fifo_rclk_fab_out, .first_multiplier_pll_ref_out,
  .second_multiplier_pll_ref_out);

// ### test/cpr_host_model.sv
// Register-port master standing in for the reconfiguration user logic.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
module cpr_host_model (
  input wire mclk_in,
  input wire [15:0] rd_data_in,
  output reg [3:0] addr_out,
  output reg [15:0] wdata_out,
  output reg wr_out,
  output reg rd_out
);
  initial begin
    addr_out = 4'h0;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // Idle cycle after each access; released lines invert so stale values never match
  task wr(input [3:0] a, input [15:0] d);
    begin
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge mclk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
      @(posedge mclk_in);
    end
  endtask
  task rd(input [3:0] a, output [15:0] d);
    begin
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge mclk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      #1 d = rd_data_in;
      @(posedge mclk_in);
    end
  endtask
endmodule

// ### test/cpr_reconfig_top_tb.sv
// Self-checking bench for the reconfiguration clock-select block.
// Assumes the host model owns the register port; expectations kept in integers.
`timescale 1ns/1ps
`include "cpr_consts.vh"
module cpr_reconfig_top_tb;
  reg mclk_in = 1'b0;
  reg rst_in = 1'b1;
  wire [3:0] addr;
  wire [15:0] wdata;
  wire [15:0] rdata;
  wire wr;
  wire rd;
  wire busy;
  wire [3:0] psel;
  wire [7:0] wsel;
  wire [3:0] rfab;
  wire [3:0] ref0;
  wire [3:0] ref1;
  integer err_count = 0;
  integer num_checks = 0;
  integer seed = 50;
  integer i, n, alt, e;
  integer kind [0:3];
  integer pll [0:3];
  integer pref [0:1];
  integer img [0:5];
  integer mcsl [0:3];
  integer mpma [0:3];
  integer mdiv [0:3];
  integer mcfg [0:1];
  reg [15:0] d;
  always #5 mclk_in = ~mclk_in;
  cpr_host_model u_cpr_host_model (.mclk_in(mclk_in), .rd_data_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  cpr_reconfig_top u_cpr_reconfig_top (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .busy_out(busy),
    .ch_tx_pll_sel_out(psel), .tx_fifo_wclk_sel_out(wsel), .rx_fifo_rclk_fab_out(rfab),
    .first_multiplier_pll_ref_out(ref0), .second_multiplier_pll_ref_out(ref1));
  task chk(input [15:0] got, input integer exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp[15:0]) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp[15:0]);
      end
    end
  endtask
  task summarize;
    begin
      if (err_count == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task apply(input integer c, input integer k, input integer l, input integer r,
      input integer p, input integer cs);
    integer dv;
    integer rv;
    integer ph;
    begin
      u_cpr_host_model.wr(`CPR_A_CLKSEL, cs[15:0]);
      u_cpr_host_model.wr(`CPR_A_IMGADDR, 16'h0000);
      e = k | (l << 2) | (r << 4) | (p << 8);
      u_cpr_host_model.wr(`CPR_A_IMGDATA, e[15:0]);
      for (n = 1; n < 6; n = n + 1) begin
        e = $random(seed);
        img[n] = e & 32'hffff;
        u_cpr_host_model.wr(`CPR_A_IMGDATA, e[15:0]);
      end
      e = 1 | (c << 4);
      u_cpr_host_model.wr(`CPR_A_CTRL, e[15:0]);
      // Second start lands while busy and must be ignored
      u_cpr_host_model.wr(`CPR_A_CTRL, 16'h0001);
      #1 n = 0;
      while (busy !== 1'b0 && n < 20) begin
        @(posedge mclk_in);
        #1 n = n + 1;
      end
      if (n == 20) begin
        err_count = err_count + 1;
        summarize;
      end
      @(posedge mclk_in);
      #1 ph = l ^ alt;
      dv = kind[c] * k == 2;
      rv = r >= `CPR_MAX_REFCLK;
      if (!dv && !rv) begin
        kind[c] = k;
        pll[c] = ph;
        pref[ph] = r;
        mcsl[c] = img[1];
        mpma[c] = img[2];
        mdiv[c] = ((img[4] & 255) << 8) | (img[3] & 255);
        mcfg[ph] = img[5];
        chk(wsel[2*c +: 2], p ? 3 : cs[0] ? 2 : cs[2] ? 1 : 0);
        chk(rfab[c], p ? 0 : cs[1]);
      end
      chk(psel[c], pll[c]);
      chk(ref0, pref[0]);
      chk(ref1, pref[1]);
      @(posedge mclk_in);
      u_cpr_host_model.rd(`CPR_A_STATUS, d);
      chk(d & 16'h000f, rv * 4 + dv * 2 + (!dv && !rv) * 8);
      u_cpr_host_model.rd(`CPR_A_CSL, d);
      chk(d, mcsl[c]);
      u_cpr_host_model.rd(`CPR_A_PMA, d);
      chk(d, mpma[c]);
      u_cpr_host_model.rd(`CPR_A_DIV, d);
      chk(d, mdiv[c]);
      u_cpr_host_model.rd(`CPR_A_PLLCFG, d);
      chk(d, mcfg[pll[c]]);
    end
  endtask
  initial begin
    for (i = 0; i < 4; i = i + 1) begin
      kind[i] = 0;
      pll[i] = 0;
      mcsl[i] = 0;
      mpma[i] = 0;
      mdiv[i] = 0;
    end
    mcfg[0] = 0;
    mcfg[1] = 0;
    pref[0] = 0;
    pref[1] = 0;
    alt = 0;
    repeat (12) @(posedge mclk_in);
    chk({psel, rfab, ref0, ref1}, 0);
    chk({8'h00, wsel}, 0);
    rst_in <= 1'b0;
    u_cpr_host_model.wr(`CPR_A_CTRL, 16'h0011);
    #1 chk(busy, 0);
    @(posedge mclk_in);
    u_cpr_host_model.wr(`CPR_A_ALTIDX, 16'h0000);
    for (i = 0; i < 8; i = i + 1) begin
      e = $random(seed);
      apply(1 + {$random(seed)} % 3, 0, e[0], {$random(seed)} % 10, e[3:1] == 0, e[6:4]);
    end
    apply(2, 0, 0, 9, 1, 7);
    apply(2, 0, 1, 10, 0, 4);
    // Channels move to the other PLL before their old one is rewritten
    u_cpr_host_model.wr(`CPR_A_ALTIDX, 16'h0001);
    alt = 1;
    apply(1, 0, 0, 4, 0, 4);
    apply(3, 1, 1, 2, 0, 0);
    apply(3, 2, 1, 3, 0, 0);
    apply(3, 0, 0, 5, 0, 1);
    u_cpr_host_model.wr(`CPR_A_IMGADDR, 16'h0001);
    u_cpr_host_model.rd(`CPR_A_IMGDATA, d);
    chk(d, img[1]);
    u_cpr_host_model.rd(`CPR_A_IMGDATA, d);
    chk(d, img[2]);
    u_cpr_host_model.rd(4'hf, d);
    chk(d, 0);
    summarize;
  end
endmodule
